// ### pkg/sbp_pkg.sv
// ============================================================
// Shared constants and types
package sbp_pkg;

   // Organisation defaults: 512K words of 36 bits, four lanes
   localparam int ADDR_W_DEF   = 19;
   localparam int LANES_DEF    = 4;
   localparam int LANE_W       = 9;

   // Burst counter width: four beats per burst
   localparam int BURST_W      = 2;

   // Qualified edges from address capture to read data out
   localparam int READ_LATENCY = 2;

   // Qualified edges from write command to its data and lane selects
   localparam int WDATA_DELAY  = 2;

   // Kind of operation travelling down the pipeline
   typedef enum logic [1:0] {
      SLOT_IDLE  = 2'b00,
      SLOT_READ  = 2'b01,
      SLOT_WRITE = 2'b10
   } sbp_slot_t;

   // Values after reset
   localparam sbp_slot_t SLOT_RST = SLOT_IDLE;
   localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;

endpackage : sbp_pkg

// ### pkg/sbp_burst_if.sv
`timescale 1ns/10ps
// ============================================================
// Burst address request and answer
interface sbp_burst_if #(parameter int ADDR_W = 19);
   logic              load;
   logic              advance;
   logic              linear;
   logic [ADDR_W-1:0] start_addr;
   logic [ADDR_W-1:0] cur_addr;

   modport gen  (input load, advance, linear, start_addr,
                 output cur_addr);
   modport user (output load, advance, linear, start_addr,
                 input cur_addr);
endinterface : sbp_burst_if

// ### rtl/sbp_lane_mem.sv
`timescale 1ns/10ps
// ============================================================
// One byte lane of the array, registered read port
module sbp_lane_mem #(
   parameter int AW = 19,
   parameter int W  = 9
) (
   // Clock
   input  wire logic          clk,
   // Write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [W-1:0]  wr_data,
   // Read port
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [W-1:0]  rd_data
);

   logic [W-1:0] mem [0:(2**AW)-1];

   // Self-timed write, completes inside the qualified edge
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data; // R6
      end
   end

   // Read with forwarding of a write landing on the same edge
   always_ff @(posedge clk) begin
      if (rd_en) begin
         if (wr_en && wr_addr == rd_addr) begin
            rd_data <= wr_data;
         end else begin
            rd_data <= mem[rd_addr];
         end
      end
   end

endmodule : sbp_lane_mem

// ### rtl/sbp_burst_gen.sv
`timescale 1ns/10ps
// ============================================================
// Four-beat burst address sequencer
module sbp_burst_gen
   import sbp_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Request from the port
   sbp_burst_if.gen  bus
);

   logic [ADDR_W-1:0]  base_q;
   logic [BURST_W-1:0] cnt_q;
   logic [BURST_W-1:0] cnt_d;
   logic [BURST_W-1:0] low;

   // Next beat count
   assign cnt_d = bus.load ? BURST_CNT_RST : cnt_q + 2'h1;

   // Base address and beat counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         base_q <= '0;
         cnt_q  <= BURST_CNT_RST;
      end else if (bus.load) begin
         base_q <= bus.start_addr;
         cnt_q  <= BURST_CNT_RST;
      end else if (bus.advance) begin
         cnt_q  <= cnt_d;
      end
   end

   // Linear adds the count, interleaved flips low bits
   always_comb begin
      if (bus.linear) begin
         low = base_q[BURST_W-1:0] + cnt_q; // R10
      end else begin
         low = base_q[BURST_W-1:0] ^ cnt_q; // R10
      end
   end

   assign bus.cur_addr = {base_q[ADDR_W-1:BURST_W], low};

endmodule : sbp_burst_gen

// ### rtl/sbp_sram_port.sv
`timescale 1ns/10ps
// Summary of operation
// R1: Address, command, byte selects and write data registered on rising edge.
// R2: Read data leaves through output registers updated on the rising edge.
// R3: Clock qualifier high freezes every register; prior cycle is extended. The sleep and burst-mode synchronisers here still move on every edge.
// R4: Reads and writes may follow in consecutive cycles, no idle cycle needed.
// R5: Write strobe plus per-lane selects; only selected byte lanes change.
// R6: Writes finish by internal clocked logic, no external write pulse.
// R7: Cycle selected only with first and third selects low, second high.
// R8: Asynchronous active-low output enable can float data outputs anytime.
// R9: Output drivers are off during cycles carrying write data.
// R10: Bursts step linear or interleaved, chosen by a static mode input.
// R11: Sleep request enters low power; stored contents survive clock stop.
// R12: Read data appears after second qualified edge after address capture.
// R13: Master drives write data and lane selects after second qualified edge.
module sbp_sram_port
   import sbp_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int LANES  = LANES_DEF
) (
   // Clock and reset
   input  wire logic                    REF_CLK,
   input  wire logic                    SYS_RST,
   // Command inputs
   input  wire logic                    CLOCK_QUALIFY_N,
   input  wire logic [ADDR_W-1:0]       ADDR,
   input  wire logic                    WRITE_EN_N,
   input  wire logic                    BURST_ADV,
   input  wire logic                    CHIP_SEL_FIRST_N,
   input  wire logic                    CHIP_SEL_SECOND,
   input  wire logic                    CHIP_SEL_THIRD_N,
   input  wire logic [LANES-1:0]        BYTE_LANE_WRITE_SEL_N,
   // Static and asynchronous controls
   input  wire logic                    BURST_LINEAR,
   input  wire logic                    SLEEP_REQUEST,
   input  wire logic                    OUT_EN_N,
   // Data pins
   input  wire logic [LANES*LANE_W-1:0] DQ_IN,
   output logic      [LANES*LANE_W-1:0] DQ_OUT,
   output logic                         DQ_OE,
   // Status
   output logic                         SLEEP_ACTIVE
);

   localparam int DATA_W = LANES * LANE_W;

   logic              run;
   logic              cs_ok;
   logic              slp_meta_q, slp_q;
   logic              lin_meta_q, lin_q;
   sbp_slot_t         kind_q, kind_d;
   sbp_slot_t         s2_kind_q, s3_kind_q;
   sbp_slot_t         s4_kind_q;
   logic [ADDR_W-1:0] s1_addr;
   logic [ADDR_W-1:0] s2_addr_q, s3_addr_q;
   logic [ADDR_W-1:0] s4_addr_q;
   logic [DATA_W-1:0] dq_in_q;
   logic [LANES-1:0]  bw_q;
   logic [LANES-1:0]  lane_we;
   logic [DATA_W-1:0] mem_rd;
   logic [DATA_W-1:0] rd_merge;
   logic [DATA_W-1:0] dout_q;
   logic              drive_q;

   sbp_burst_if #(.ADDR_W(ADDR_W)) burst ();

   // ==========================================================
   // Clock qualification and select decode

   // Qualified edge: every register below except the sleep and burst-mode synchronisers moves only on it
   assign run   = ~CLOCK_QUALIFY_N; // R3
   assign cs_ok = ~CHIP_SEL_FIRST_N & CHIP_SEL_SECOND
                  & ~CHIP_SEL_THIRD_N; // R7

   // ==========================================================
   // Synchronisers for sleep and burst mode pins

   // Two-stage capture of the asynchronous sleep request
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         slp_meta_q <= 1'b0;
         slp_q      <= 1'b0;
      end else begin
         slp_meta_q <= SLEEP_REQUEST;
         slp_q      <= slp_meta_q; // R11
      end
   end

   // Two-stage capture of the static burst order strap
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lin_meta_q <= 1'b0;
         lin_q      <= 1'b0;
      end else begin
         lin_meta_q <= BURST_LINEAR;
         lin_q      <= lin_meta_q;
      end
   end

   assign SLEEP_ACTIVE = slp_q;

   // ==========================================================
   // Input registers: command and burst address

   // New command on load, burst continues previous kind
   always_comb begin
      if (slp_q) begin
         kind_d = SLOT_IDLE; // R11
      end else if (BURST_ADV) begin
         kind_d = kind_q;
      end else if (!cs_ok) begin
         kind_d = SLOT_IDLE; // R7
      end else if (!WRITE_EN_N) begin
         kind_d = SLOT_WRITE;
      end else begin
         kind_d = SLOT_READ;
      end
   end

   // Command kind register
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         kind_q <= SLOT_RST;
      end else if (run) begin
         kind_q <= kind_d; // R1
      end
   end

   // Burst sequencer holds the captured address
   assign burst.load       = run & ~BURST_ADV & cs_ok & ~slp_q; // R1
   assign burst.advance    = run & BURST_ADV;
   assign burst.linear     = lin_q; // R10
   assign burst.start_addr = ADDR;
   assign s1_addr          = burst.cur_addr;

   sbp_burst_gen #(.ADDR_W(ADDR_W)) u_burst (
      .clk (REF_CLK),
      .rst (SYS_RST),
      .bus (burst)
   );

   // Write data and lane selects, registered every qualified edge
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         dq_in_q <= '0;
         bw_q    <= '0;
      end else if (run) begin
         dq_in_q <= DQ_IN;                  // R1
         bw_q    <= ~BYTE_LANE_WRITE_SEL_N; // R13
      end
   end

   // ==========================================================
   // Pipeline stages: access and write-data slots

   // Slots shift one place per qualified edge, no bubbles
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s2_kind_q <= SLOT_RST;
         s3_kind_q <= SLOT_RST;
         s4_kind_q <= SLOT_RST;
         s2_addr_q <= '0;
         s3_addr_q <= '0;
         s4_addr_q <= '0;
      end else if (run) begin
         s2_kind_q <= kind_q;    // R4
         s3_kind_q <= s2_kind_q; // R4
         s4_kind_q <= s3_kind_q; // R4
         s2_addr_q <= s1_addr;
         s3_addr_q <= s2_addr_q;
         s4_addr_q <= s3_addr_q;
      end
   end

   // ==========================================================
   // Byte-lane array

   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         // Only selected lanes of a committing write change
         assign lane_we[gi] = run & (s4_kind_q == SLOT_WRITE)
                              & bw_q[gi]; // R5

         sbp_lane_mem #(.AW(ADDR_W), .W(LANE_W)) u_mem (
            .clk     (REF_CLK),
            .wr_en   (lane_we[gi]),
            .wr_addr (s4_addr_q),
            .wr_data (dq_in_q[gi*LANE_W +: LANE_W]),
            .rd_en   (run & (kind_q == SLOT_READ)),
            .rd_addr (s1_addr),
            .rd_data (mem_rd[gi*LANE_W +: LANE_W])
         );

         // Forward writes not yet in the array, newest first
         assign rd_merge[gi*LANE_W +: LANE_W] =
            (s3_kind_q == SLOT_WRITE && !BYTE_LANE_WRITE_SEL_N[gi]
             && s3_addr_q == s2_addr_q)
            ? DQ_IN[gi*LANE_W +: LANE_W] // R4
            : (lane_we[gi] && s4_addr_q == s2_addr_q)
            ? dq_in_q[gi*LANE_W +: LANE_W]
            : mem_rd[gi*LANE_W +: LANE_W];
      end
   endgenerate

   // ==========================================================
   // Output register and driver control

   // Read data launched from the output register
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         dout_q <= '0;
      end else if (run && s2_kind_q == SLOT_READ) begin
         dout_q <= rd_merge; // R2 R12
      end
   end

   // Drive only in read data slots, off during write data
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         drive_q <= 1'b0;
      end else if (run) begin
         drive_q <= (s2_kind_q == SLOT_READ); // R9 R12
      end
   end

   assign DQ_OUT = dout_q;
   assign DQ_OE  = drive_q & ~OUT_EN_N; // R8

   // ==========================================================
   // Assertions

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);

   sequence s_read_cmd;
      run && kind_q == SLOT_READ;
   endsequence

   sequence s_write_cmd;
      run && kind_d == SLOT_WRITE && !BURST_ADV;
   endsequence

   sequence s_two_run;
      run ##1 run;
   endsequence

   AST_CAPTURE: assert property ( // R1
      s_write_cmd |=> kind_q == SLOT_WRITE)
      else $error("write command not captured");

   AST_OUT_REG: assert property ( // R2
      $changed(dout_q) |-> $past(run) && $past(s2_kind_q) == SLOT_READ)
      else $error("output register moved outside a read slot");

   AST_HOLD: assert property ( // R3
      !run |=> $stable(dout_q) && $stable(drive_q) && $stable(kind_q)
               && $stable(s2_kind_q) && $stable(s3_kind_q))
      else $error("state changed on an unqualified edge");

   AST_NO_BUBBLE: assert property ( // R4
      run && kind_q != SLOT_IDLE |=> s2_kind_q == $past(kind_q))
      else $error("operation lost between stages");

   AST_LANE_ONLY: assert property ( // R5
      lane_we != '0 |-> run && s4_kind_q == SLOT_WRITE
                        && (lane_we & ~bw_q) == '0)
      else $error("unselected lane written");

   AST_SELF_TIMED: assert property ( // R6
      s_write_cmd ##1 s_two_run ##1 s_two_run
      |-> lane_we == ~$past(BYTE_LANE_WRITE_SEL_N))
      else $error("write did not commit on the edge after its data");

   AST_DESELECT: assert property ( // R7
      run && !BURST_ADV && !cs_ok |=> kind_q == SLOT_IDLE)
      else $error("deselected cycle started an access");

   AST_ASYNC_OE: assert property ( // R8
      OUT_EN_N |-> !DQ_OE)
      else $error("outputs driven with output enable high");

   AST_WRITE_FLOAT: assert property ( // R9
      run && s2_kind_q == SLOT_WRITE |=> !drive_q)
      else $error("outputs driven during write data");

   AST_DRIVE_SLOT: assert property ( // R9
      run && s2_kind_q != SLOT_READ |=> !drive_q)
      else $error("outputs driven outside a read data slot");

   AST_LINEAR_STEP: assert property ( // R10
      run && BURST_ADV && lin_q && $stable(lin_q) && !burst.load
      |=> s1_addr[BURST_W-1:0] == $past(s1_addr[BURST_W-1:0]) + 2'h1)
      else $error("linear burst did not step by one");

   AST_SLEEP_IDLE: assert property ( // R11
      run && slp_q |=> kind_q == SLOT_IDLE)
      else $error("access started while asleep");

   AST_READ_LAT: assert property ( // R12
      s_read_cmd ##1 s_two_run |-> drive_q)
      else $error("read data late after second qualified edge");

endmodule : sbp_sram_port

// ### tb/sbp_master_model.sv
`timescale 1ns/10ps
// ============================================================
// Bus master model: issues commands, feeds write data late
module sbp_master_model
   import sbp_pkg::*;
#(
   parameter int AW = 8,
   parameter int LN = 4
) (
   // Clock
   input  wire logic                 clk,
   // Command pins
   output logic                      qual_n,
   output logic [AW-1:0]             addr,
   output logic                      we_n,
   output logic                      adv,
   output logic [2:0]                cs,
   // Write data pins
   output logic [LN-1:0]             lane_n,
   output logic [LN*LANE_W-1:0]      dq,
   // Expected answer of the port
   output logic [1:0]                exp_k,
   output logic [LN*LANE_W-1:0]      exp_d
);
   typedef struct {
      logic                 st;
      logic                 we_n;
      logic                 adv;
      logic [2:0]           cs;
      logic [AW-1:0]        a;
      logic [LN*LANE_W-1:0] d;
      logic [LN*LANE_W-1:0] x;
      logic [LN-1:0]        ln;
      logic [1:0]           k;
   } sbp_cmd_t;

   sbp_cmd_t cq[$];
   sbp_cmd_t a_q, b_q, c_q, d_q, idle;
   logic     took;

   // Queue one command or stall cycle
   task put(input logic st, w, v, input logic [2:0] c,
            input logic [AW-1:0] a, input logic [LN*LANE_W-1:0] d, x,
            input logic [LN-1:0] l, input logic [1:0] k);
      cq.push_back('{st, w, v, c, a, d, x, l, k});
   endtask : put

   // Idle bus at time zero, deselected
   initial begin
      idle = '{1'b0, 1'b1, 1'b0, 3'b111, '0, '0, '0, '1, 2'h2};
      a_q = idle;
      b_q = idle;
      c_q = idle;
      d_q = idle;
      qual_n = 1'b0;
      addr = '0;
      we_n = 1'b1;
      adv = 1'b0;
      cs = 3'b111;
      lane_n = '1;
      dq = '0;
      exp_k = 2'h2;
      exp_d = '0;
   end

   // Pipeline moves on qualified edges only
   always @(posedge clk) begin
      took = !qual_n;
      #1;
      if (took) begin
         d_q = c_q;
         c_q = b_q;
         b_q = a_q;
      end
      a_q = (cq.size() > 0) ? cq.pop_front() : idle;
      qual_n = a_q.st;
      if (!a_q.st) begin
         addr = a_q.a;
         we_n = a_q.we_n;
         adv = a_q.adv;
         cs = a_q.cs;
      end
      // Released data lines toggle; write data after second edge
      dq = (d_q.k == 2'h3) ? d_q.d : ~dq;
      lane_n = (d_q.k == 2'h3) ? d_q.ln : '1;
      exp_k = d_q.k;
      exp_d = d_q.x;
   end
endmodule : sbp_master_model

// ### tb/tb.sv
`timescale 1ns/10ps
// ============================================================
// Self-checking bench for the burst SRAM port
`define CHK(got, exp) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
   end \
end

module tb;
   import sbp_pkg::*;

   localparam int         AW  = 8;
   localparam logic [2:0] SEL = 3'b010;

   logic            ref_clk, sys_rst, burst_linear, sleep_request;
   logic            out_en_n, qual_n, we_n, adv, dq_oe, sleep_active;
   logic [2:0]      cs;
   logic [AW-1:0]   addr, bs;
   logic [3:0]      lane_n;
   logic [35:0]     dq_in, dq_out, exp_d;
   logic [1:0]      exp_k, cnt, lk;
   logic            lin, slp, mon_en;
   logic [35:0]     mem [logic [AW-1:0]];
   int              err_count = 0;
   int              samples_checked = 0;

   // ============================================================
   // Clock, device and master
   initial ref_clk = 1'b0;
   always #20 ref_clk = ~ref_clk;

   sbp_sram_port #(.ADDR_W(AW), .LANES(4)) uut (
      .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLOCK_QUALIFY_N(qual_n),
      .ADDR(addr), .WRITE_EN_N(we_n), .BURST_ADV(adv),
      .CHIP_SEL_FIRST_N(cs[2]), .CHIP_SEL_SECOND(cs[1]),
      .CHIP_SEL_THIRD_N(cs[0]), .BYTE_LANE_WRITE_SEL_N(lane_n),
      .BURST_LINEAR(burst_linear), .SLEEP_REQUEST(sleep_request),
      .OUT_EN_N(out_en_n), .DQ_IN(dq_in), .DQ_OUT(dq_out),
      .DQ_OE(dq_oe), .SLEEP_ACTIVE(sleep_active));

   sbp_master_model #(.AW(AW), .LN(4)) mdl (
      .clk(ref_clk), .qual_n(qual_n), .addr(addr), .we_n(we_n),
      .adv(adv), .cs(cs), .lane_n(lane_n), .dq(dq_in),
      .exp_k(exp_k), .exp_d(exp_d));

   // ============================================================
   // Tasks
   task end_sim;
      $display("Checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   // One command, with its expected answer worked out
   task op(input logic w, v, input logic [2:0] c, input logic [AW-1:0] a,
           input logic [35:0] d, input logic [3:0] ln);
      logic [AW-1:0] ea;
      if (!v) begin
         bs = a;
         cnt = 2'h0;
         lk = (c != SEL || slp) ? 2'h2 : (w ? 2'h1 : 2'h3);
      end else cnt = cnt + 2'h1;
      ea = {bs[AW-1:2], lin ? bs[1:0] + cnt : bs[1:0] ^ cnt};
      if (lk == 2'h3)
         for (int i = 0; i < 4; i++)
            if (!ln[i]) mem[ea][9*i+:9] = d[9*i+:9];
      mdl.put(1'b0, w, v, c, a, d, mem[ea], ln, lk);
   endtask : op

   task stl;
      mdl.put(1'b1, 1'b1, 1'b0, 3'b111, '0, '0, '0, '1, 2'h2);
   endtask : stl

   // Drain the command queue, bounded
   task flush;
      int n;
      n = 0;
      while (mdl.cq.size() > 0 && n < 500) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 500) begin
         err_count++;
         end_sim();
      end
      repeat (5) @(posedge ref_clk);
      #1;
   endtask : flush

   task wait_sleep(input logic v);
      int n;
      n = 0;
      while (sleep_active !== v && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      `CHK(sleep_active, v)
      if (n == 20) end_sim();
   endtask : wait_sleep

   // Judge the read port after every edge
   always @(posedge ref_clk) begin
      #3;
      if (mon_en) begin
         `CHK(dq_oe, (exp_k == 2'h1) && !out_en_n)
         if (exp_k == 2'h1) `CHK(dq_out, exp_d)
      end
   end

   // ============================================================
   // Scenarios
   task t_b2b;
      op(0, 0, SEL, 8'h10, 36'h123456789, 4'h0);
      op(1, 0, SEL, 8'h10, 36'h0, 4'hF);
      op(0, 0, SEL, 8'h10, 36'hFEDCBA987, 4'hA);
      op(1, 0, SEL, 8'h10, 36'h0, 4'hF);
      op(0, 0, SEL, 8'h11, 36'h0F0F0F0F0, 4'h0);
      op(1, 0, SEL, 8'h11, 36'h0, 4'hF);
      op(1, 0, SEL, 8'h10, 36'h0, 4'hF);
      flush();
      $display("back to back done");
   endtask : t_b2b

   task t_sel;
      for (int c = 0; c < 8; c++) begin
         op(0, 0, SEL, AW'(8'h20 + c), 36'h111111111, 4'h0);
         op(0, 0, c[2:0], AW'(8'h20 + c), 36'h2AAAAAAAA, 4'h0);
         op(1, 0, SEL, AW'(8'h20 + c), 36'h0, 4'hF);
         op(1, 0, c[2:0], AW'(8'h20 + c), 36'h0, 4'hF);
      end
      flush();
      $display("chip selects done");
   endtask : t_sel

   task t_stall;
      op(0, 0, SEL, 8'h30, 36'h3C3C3C3C3, 4'h0);
      stl();
      stl();
      op(1, 0, SEL, 8'h30, 36'h0, 4'hF);
      stl();
      op(0, 0, SEL, 8'h31, 36'h5A5A5A5A5, 4'h0);
      stl();
      stl();
      stl();
      op(1, 0, SEL, 8'h31, 36'h0, 4'hF);
      op(1, 0, SEL, 8'h30, 36'h0, 4'hF);
      stl();
      stl();
      flush();
      $display("stall done");
   endtask : t_stall

   task t_burst;
      for (int m = 0; m < 2; m++) begin
         burst_linear = m[0];
         lin = m[0];
         repeat (4) @(posedge ref_clk);
         #1;
         op(0, 0, SEL, 8'h41, 36'h0AB000001, 4'h0);
         for (int j = 1; j < 4; j++)
            op(0, 1, SEL, 8'h00, 36'(j * 7 + m * 100 + 5), 4'h0);
         for (int j = 0; j < 4; j++)
            op(1, 0, SEL, AW'(8'h40 + j), 36'h0, 4'hF);
         op(1, 0, SEL, 8'h42, 36'h0, 4'hF);
         for (int j = 1; j < 4; j++) op(1, 1, SEL, 8'h00, 36'h0, 4'hF);
         flush();
      end
      $display("burst order done");
   endtask : t_burst

   task t_sleep;
      sleep_request = 1'b1;
      wait_sleep(1'b1);
      slp = 1'b1;
      op(1, 0, SEL, 8'h10, 36'h0, 4'hF);
      op(0, 0, SEL, 8'h10, 36'h000000000, 4'h0);
      flush();
      sleep_request = 1'b0;
      wait_sleep(1'b0);
      repeat (2) @(posedge ref_clk);
      #1 slp = 1'b0;
      op(1, 0, SEL, 8'h10, 36'h0, 4'hF);
      flush();
      $display("sleep done");
   endtask : t_sleep

   task t_oe;
      int n;
      out_en_n = 1'b1;
      op(1, 0, SEL, 8'h11, 36'h0, 4'hF);
      flush();
      out_en_n = 1'b0;
      for (int j = 0; j < 4; j++) op(1, 0, SEL, 8'h11, 36'h0, 4'hF);
      n = 0;
      do begin
         @(posedge ref_clk);
         #3;
         n++;
      end while (dq_oe !== 1'b1 && n < 10);
      if (dq_oe !== 1'b1) begin
         err_count++;
         end_sim();
      end
      #5 out_en_n = 1'b1;
      #1 `CHK(dq_oe, 1'b0)
      out_en_n = 1'b0;
      #1 `CHK(dq_oe, 1'b1)
      flush();
      $display("output enable done");
   endtask : t_oe

   // ============================================================
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      burst_linear = 1'b1;
      lin = 1'b1;
      slp = 1'b0;
      sleep_request = 1'b0;
      out_en_n = 1'b0;
      mon_en = 1'b0;
      repeat (10) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      mon_en = 1'b1;
      t_b2b();
      t_sel();
      t_stall();
      t_burst();
      t_sleep();
      t_oe();
      end_sim();
   end
endmodule : tb
